/* memory_bank_address_logic.sv */
// memory bank address logic: core address to 24-bit physical address,
// boot rom / flash select, and its registers on an ahb-lite slave.
// assumes core address signals come from logic on clk_i; the phase-two
// clock and the test pin are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - native mode holds the bank byte while phase two is high.
// - mode flag 0 gives native banking (reset), 1 gives alternative.
// - alternative mode picks one upper 32 KB bank by bank select.
// - bank select is an ordinary readable and writable 8-bit register.
// - a bank select write switches the upper window at once.
// - bank select 0 makes the upper window mirror the lower 32 KB.
// - reset loads bank select with 1.
// - in alternative mode, upper-window vector fetches use bank 1 without touching bank select.
// - after a vector fetch, window accesses use bank select again.
// - native mode passes logical address straight to physical.
// - alternative mode drops bit 15 and keeps the map contiguous.
// - with bank byte zero, native accesses stay in the first 64 KB.
// - boot rom decodes 00f800 to 00ffff while enabled.
// - at reset with test pin low the boot control word is loaded.
// - program-store flag 0 keeps boot rom, 1 maps flash there.
module memory_bank_address_logic (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // ahb-lite register bus
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output var  logic [31:0] hrdata_o,
    output var  logic        hreadyout_o,
    output var  logic        hresp_o,
    // processor core side
    input  wire logic        cpu_phase_two_clock_i,
    input  wire logic [7:0]  cpu_data_addr_i,
    input  wire logic [15:0] cpu_addr_i,
    input  wire logic        cpu_vector_fetch_i,
    // control word sources and test strap
    input  wire logic        test_pin_i,
    input  wire logic [7:0]  boot_ctrl_word_i,
    input  wire logic [7:0]  ext_ctrl_word_i,
    // memory side
    output var  logic [23:0] phys_addr_o,
    output var  logic        boot_rom_sel_o,
    output var  logic        flash_sel_o,
    output var  logic        alt_bank_mode_flag_o
);
    import bank_map_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]  alt_bank_select;
    logic [7:0]  system_reg_two;
    logic [7:0]  control_reg;
    logic [7:0]  bank_latch;
    logic        phase_two;
    logic        test_level;
    logic [1:0]  load_count;
    logic        ctrl_loaded;
    logic        wr_pending;
    logic [7:0]  wr_offset;
    logic [23:0] next_phys;
    logic        in_boot_range;
    logic        take_req;
    logic [SYNC_STAGES:0][7:0] data_delay;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // word offset of a bus address, low byte only
    function automatic logic [7:0] word_offset(input logic [31:0] addr);
        return {addr[7:2], 2'b00};
    endfunction

    // true when the upper address bits lie outside the register block
    function automatic logic off_block(input logic [31:0] addr);
        return |addr[31:8];
    endfunction

    // a write in its data phase aimed at the given word offset;
    // shared by the register updates and the read bypass
    function automatic logic write_hits(input logic [7:0] ofs);
        return wr_pending && wr_offset == ofs;
    endfunction

    // offsets that software can write
    function automatic logic writable(input logic [7:0] ofs);
        return ofs == OFS_ALT_BANK_SELECT || ofs == OFS_SYSTEM_REG_TWO
            || ofs == OFS_CONTROL_REG;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    pin_sync #(
        .WIDTH     (2),
        .RESET_VAL (1'b0)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   ({cpu_phase_two_clock_i, test_pin_i}),
        .level_o ({phase_two, test_level})
    );

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    assign take_req = hsel_i && hready_i
                   && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);

    // zero wait states, always okay
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hreadyout_o <= 1'b0;
            hresp_o     <= HRESP_OKAY;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= HRESP_OKAY;
        end
    end

    // address phase of a write, carried into its data phase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pending <= 1'b0;
            wr_offset  <= 8'h00;
        end else if (hready_i) begin
            wr_pending <= take_req && hwrite_i && !off_block(haddr_i);
            wr_offset  <= word_offset(haddr_i);
        end
    end

    // read data registered at the address phase edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (take_req && !hwrite_i) begin
            hrdata_o <= 32'h0000_0000;
            if (!off_block(haddr_i)) begin
                unique case (word_offset(haddr_i))
                    OFS_ALT_BANK_SELECT: begin
                        hrdata_o <= {24'h000000, alt_bank_select};
                    end
                    OFS_SYSTEM_REG_TWO: begin
                        hrdata_o <= {24'h000000, system_reg_two};
                    end
                    OFS_CONTROL_REG: begin
                        hrdata_o <= {24'h000000, control_reg};
                    end
                    OFS_PHYS_STATUS: begin
                        hrdata_o <= {8'h00, phys_addr_o};
                    end
                    default: begin
                        hrdata_o <= 32'h0000_0000;
                    end
                endcase
                // a write still in its data phase wins over the stored
                // value, so a back-to-back write then read sees new data
                if (write_hits(word_offset(haddr_i))
                        && writable(word_offset(haddr_i))) begin
                    hrdata_o <= {24'h000000, hwdata_i[7:0]};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    // bank select: reset value 1, written in the data phase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            alt_bank_select <= ALT_BANK_RESET;
        end else if (write_hits(OFS_ALT_BANK_SELECT)) begin
            alt_bank_select <= hwdata_i[7:0];
        end
    end

    // system register two holds the banking mode flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            system_reg_two <= SYSTEM_REG_RESET;
        end else if (write_hits(OFS_SYSTEM_REG_TWO)) begin
            system_reg_two <= hwdata_i[7:0];
        end
    end

    // ------------------------------------------------------------------
    // control word load after reset, then software control
    // ------------------------------------------------------------------
    // wait until the strap has passed the synchroniser
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            load_count  <= 2'd0;
            ctrl_loaded <= 1'b0;
        end else if (!ctrl_loaded) begin
            if (load_count == CTRL_LOAD_WAIT) begin
                ctrl_loaded <= 1'b1;
            end else begin
                load_count <= load_count + 2'd1;
            end
        end
    end

    // copy from boot rom when test pin is low, else the external word
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            control_reg <= CONTROL_RESET;
        end else if (!ctrl_loaded && load_count == CTRL_LOAD_WAIT) begin
            control_reg <= test_level ? ext_ctrl_word_i
                                      : boot_ctrl_word_i;
        end else if (write_hits(OFS_CONTROL_REG)) begin
            control_reg <= hwdata_i[7:0];
        end
    end

    // ------------------------------------------------------------------
    // native bank byte latch
    // ------------------------------------------------------------------
    // the phase level reaches the latch one synchroniser latency late;
    // the shared lines take the same number of edges, so the latch still
    // sees the bank byte and never the data that replaces it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_delay <= {(SYNC_STAGES + 1){8'h00}};
        end else begin
            data_delay <= {data_delay[SYNC_STAGES-1:0], cpu_data_addr_i};
        end
    end

    // follows the delayed lines while phase two is low (first half),
    // holds while it is high (second half)
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bank_latch <= 8'h00;
        end else if (!phase_two) begin
            bank_latch <= data_delay[SYNC_STAGES];
        end
    end

    // ------------------------------------------------------------------
    // address translation
    // ------------------------------------------------------------------
    // native: one to one; alternative: bank number above 15 offset bits
    always_comb begin
        if (!system_reg_two[ALT_BANK_MODE_BIT]) begin
            next_phys = {bank_latch, cpu_addr_i};
        end else if (!cpu_addr_i[WINDOW_SELECT_BIT]) begin
            next_phys = {9'h000, cpu_addr_i[14:0]};
        end else if (cpu_vector_fetch_i) begin
            next_phys = {1'b0, VECTOR_BANK, cpu_addr_i[14:0]};
        end else begin
            // bank 0 lands on the master bank, bank n on n * 32 KB
            next_phys = {1'b0, alt_bank_select,
                         cpu_addr_i[14:0]};
        end
    end

    assign in_boot_range = next_phys >= BOOT_ROM_FIRST
                        && next_phys <= BOOT_ROM_LAST;

    // physical address and memory selects, updated every cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phys_addr_o    <= 24'h000000;
            boot_rom_sel_o <= 1'b0;
            flash_sel_o    <= 1'b0;
        end else begin
            phys_addr_o    <= next_phys;
            boot_rom_sel_o <= in_boot_range
                           && !control_reg[PROG_STORE_BIT];
            flash_sel_o    <= in_boot_range
                           && control_reg[PROG_STORE_BIT];
        end
    end

    // mode flag mirrored to the memory side
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            alt_bank_mode_flag_o <= 1'b0;
        end else begin
            alt_bank_mode_flag_o <= system_reg_two[ALT_BANK_MODE_BIT];
        end
    end

    // hsize is accepted but only whole words are served
    logic unused_bits;
    assign unused_bits = ^{hsize_i, hwdata_i[31:8], haddr_i[1:0]};

endmodule // memory_bank_address_logic
`default_nettype wire

/* bank_map_pkg.sv */
// constants for the memory bank address logic: register offsets, field
// positions, reset values, address ranges and bus encodings.
// assumes a 32-bit ahb-lite register bus and a 24-bit physical map.
package bank_map_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses, aligned words)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ALT_BANK_SELECT = 8'h00;
    localparam logic [7:0] OFS_SYSTEM_REG_TWO  = 8'h04;
    localparam logic [7:0] OFS_CONTROL_REG     = 8'h08;
    localparam logic [7:0] OFS_PHYS_STATUS     = 8'h0c;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int         ALT_BANK_MODE_BIT   = 0;
    localparam int         PROG_STORE_BIT      = 3;
    localparam logic [7:0] ALT_BANK_RESET      = 8'h01;
    localparam logic [7:0] SYSTEM_REG_RESET    = 8'h00;
    localparam logic [7:0] CONTROL_RESET       = 8'h00;

    // ------------------------------------------------------------------
    // address map
    // ------------------------------------------------------------------
    localparam int          WINDOW_SELECT_BIT  = 15;
    localparam logic [7:0]  VECTOR_BANK        = 8'h01;
    localparam logic [23:0] BOOT_ROM_FIRST     = 24'h00f800;
    localparam logic [23:0] BOOT_ROM_LAST      = 24'h00ffff;

    // ------------------------------------------------------------------
    // timing: cycles after reset release before the control word load
    // ------------------------------------------------------------------
    localparam int         SYNC_STAGES         = 3;
    localparam logic [1:0] CTRL_LOAD_WAIT      = 2'(SYNC_STAGES);

    // ------------------------------------------------------------------
    // ahb-lite encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ       = 2'b10;
    localparam logic [1:0] HTRANS_SEQ          = 2'b11;
    localparam logic       HRESP_OKAY          = 1'b0;

endpackage

/* pin_sync.sv */
// three-stage synchroniser for pin inputs with agreement filter.
// assumes an asynchronous input; output moves only when stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [0:0] RESET_VAL = 1'b0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output var  logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] stage_two;
    logic [WIDTH-1:0] stage_three;

    // refuse a width the logic cannot serve
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync width must be at least one");
    end

    // shift chain; the first stage feeds only the second. no reset here,
    // so the chain already holds the pin level when reset is released
    always_ff @(posedge clk_i) begin
        stage_one   <= pin_i;
        stage_two   <= stage_one;
        stage_three <= stage_two;
    end

    // accept a change once stages two and three agree
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            level_o <= {WIDTH{RESET_VAL}};
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage_two[i] == stage_three[i]) begin
                    level_o[i] <= stage_three[i];
                end
            end
        end
    end

endmodule // pin_sync
`default_nettype wire

/* bank_map_props.sv */
// assertions on the ports of the bank address logic
// assumes it is bound to memory_bank_address_logic
`timescale 1ns/1ps
`default_nettype none
module bank_map_props
    import bank_map_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        cpu_phase_two_clock_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic        cpu_vector_fetch_i,
    input wire logic [23:0] phys_addr_o,
    input wire logic        boot_rom_sel_o,
    input wire logic        flash_sel_o,
    input wire logic        alt_bank_mode_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------------
    // read address phase taken at a given offset
    sequence s_rd_taken(logic [7:0] ofs);
        hsel_i && hready_i && htrans_i[1] && !hwrite_i
            && haddr_i == {24'h000000, ofs};
    endsequence
    // alternative mode settled over the last two edges
    sequence s_alt_hi;
        alt_bank_mode_flag_o && $past(alt_bank_mode_flag_o)
            && $past(alt_bank_mode_flag_o, 2);
    endsequence
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_native_map: assert property (
        !$past(rst_i) && !alt_bank_mode_flag_o
            && !$past(alt_bank_mode_flag_o)
            |-> phys_addr_o[15:0] == $past(cpu_addr_i))
        else $error("native address not passed through");
    a_latch_hold: assert property (
        (!alt_bank_mode_flag_o && cpu_phase_two_clock_i)[*6]
            |=> $stable(phys_addr_o[23:16]))
        else $error("bank byte moved while phase two high");
    a_alt_master: assert property (
        s_alt_hi ##0 !$past(cpu_addr_i[15])
            |-> phys_addr_o == {9'h000, $past(cpu_addr_i[14:0])})
        else $error("low window not in master bank");
    a_alt_window: assert property (
        s_alt_hi ##0 $past(cpu_addr_i[15])
            |-> !phys_addr_o[23]
                && phys_addr_o[14:0] == $past(cpu_addr_i[14:0]))
        else $error("window address not folded");
    a_vector_bank: assert property (
        s_alt_hi ##0 ($past(cpu_addr_i[15]) && $past(cpu_vector_fetch_i))
            |-> phys_addr_o[23:15] == {1'b0, VECTOR_BANK})
        else $error("vector fetch not in bank one");
    a_sel_exclusive: assert property (
        !(boot_rom_sel_o && flash_sel_o))
        else $error("boot rom and flash both selected");
    a_bank_read: assert property (
        s_rd_taken(OFS_ALT_BANK_SELECT) |=> hrdata_o[31:8] == 24'h000000)
        else $error("bank select read has upper bits set");
    a_unmapped_zero: assert property (
        s_rd_taken(8'h40) |=> hrdata_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_bus_okay: assert property (
        !$past(rst_i) |-> hreadyout_o && hresp_o == HRESP_OKAY)
        else $error("bus stalled or not okay");
endmodule // bank_map_props

bind memory_bank_address_logic bank_map_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .cpu_phase_two_clock_i(cpu_phase_two_clock_i),
    .cpu_addr_i(cpu_addr_i), .cpu_vector_fetch_i(cpu_vector_fetch_i),
    .phys_addr_o(phys_addr_o), .boot_rom_sel_o(boot_rom_sel_o),
    .flash_sel_o(flash_sel_o),
    .alt_bank_mode_flag_o(alt_bank_mode_flag_o));
`default_nettype wire

/* core_model.sv */
// processor core model: bank byte, address and vector fetch lines
// assumes the bench calls bus_cycle right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic        clk_i,
    output var  logic        phase_two_o,
    output var  logic [7:0]  data_addr_o,
    output var  logic [15:0] addr_o,
    output var  logic        vector_o
);
    // idle: second half, lines parked
    initial begin
        phase_two_o = 1'b1;
        data_addr_o = 8'h00;
        addr_o = 16'h0000;
        vector_o = 1'b0;
    end
    // one bus cycle: bank byte in first half, data in second half
    task automatic bus_cycle(input logic [7:0] bank, input logic [15:0] a,
                             input logic vec);
        phase_two_o <= 1'b0;
        data_addr_o <= bank;
        addr_o <= a;
        vector_o <= vec;
        repeat (5) @(posedge clk_i);
        phase_two_o <= 1'b1;
        data_addr_o <= ~bank; // data replaces bank byte
        repeat (5) @(posedge clk_i);
    endtask
endmodule // core_model
`default_nettype wire

/* memory_bank_address_logic_test.sv */
// self-checking bench for the bank address logic
// assumes core_model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module memory_bank_address_logic_test;
    import bank_map_pkg::*;
    logic        clk_i, rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
    logic [1:0]  htrans_i;
    logic        phase, vec, boot_sel, flash_sel, mode_flag;
    logic [7:0]  bank;
    logic [15:0] addr;
    logic [23:0] phys;
    logic        strap;
    logic [1:0]  sel_seen;
    int          n_mismatch, samples_checked, cycles;

    core_model core (.clk_i(clk_i), .phase_two_o(phase),
        .data_addr_o(bank), .addr_o(addr), .vector_o(vec));
    memory_bank_address_logic uut (.clk_i(clk_i), .rst_i(rst_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .cpu_phase_two_clock_i(phase), .cpu_data_addr_i(bank),
        .cpu_addr_i(addr), .cpu_vector_fetch_i(vec), .test_pin_i(strap),
        .boot_ctrl_word_i(8'h02), .ext_ctrl_word_i(8'h08),
        .phys_addr_o(phys), .boot_rom_sel_o(boot_sel),
        .flash_sel_o(flash_sel), .alt_bank_mode_flag_o(mode_flag));

    // single ahb-lite transfer, read data taken at the data phase edge
    task automatic ahb(input logic wr, input logic [31:0] a, d);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= wr;
        htrans_i <= HTRANS_NONSEQ;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    // compare and count
    task automatic check(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // core cycle then physical address compare
    task automatic core_chk(input logic [7:0] b, input logic [15:0] a,
                            input logic v, input logic [23:0] exp);
        core.bus_cycle(b, a, v);
        @(negedge clk_i); // outputs settled between edges
        sel_seen = {boot_sel, flash_sel};
        check("phys", {8'h00, exp}, {8'h00, phys});
        @(posedge clk_i);
    endtask
    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values;
        ahb(1'b0, 32'h0, 32'h0);
        check("bank select", 32'h1, rd);
        ahb(1'b0, 32'h4, 32'h0);
        check("system reg two", 32'h0, rd);
        ahb(1'b0, 32'h8, 32'h0);
        check("control", 32'h2, rd);
        ahb(1'b0, 32'h40, 32'h0);
        check("unmapped", 32'h0, rd);
    endtask
    task automatic t_native;
        core_chk(8'h12, 16'h3456, 1'b0, 24'h123456);
        core_chk(8'h00, 16'hf900, 1'b0, 24'h00f900);
        check("boot sel", 32'h1, {31'h0, sel_seen[1]});
        check("flash off", 32'h0, {31'h0, sel_seen[0]});
        ahb(1'b1, 32'h8, 32'h0a);
        core_chk(8'h00, 16'hf900, 1'b0, 24'h00f900);
        check("flash sel", 32'h1, {31'h0, sel_seen[0]});
        check("boot off", 32'h0, {31'h0, sel_seen[1]});
        ahb(1'b1, 32'h8, 32'h02);
    endtask
    task automatic t_alt;
        core_chk(8'h00, 16'h0123, 1'b0, 24'h000123);
        ahb(1'b1, 32'h4, 32'h1);
        ahb(1'b1, 32'h0, 32'h05);
        ahb(1'b0, 32'h0, 32'h0);
        check("bank select", 32'h05, rd);
        check("mode flag", 32'h1, {31'h0, mode_flag});
        core_chk(8'h33, 16'h8123, 1'b0, 24'h028123);
        core_chk(8'h33, 16'h0123, 1'b0, 24'h000123);
        core_chk(8'h33, 16'hfffe, 1'b1, 24'h00fffe);
        core_chk(8'h33, 16'hfffe, 1'b0, 24'h02fffe);
        ahb(1'b0, 32'h0, 32'h0);
        check("bank kept", 32'h05, rd);
        core_chk(8'h33, 16'h8123, 1'b0, 24'h028123);
        ahb(1'b1, 32'h0, 32'h0);
        @(posedge clk_i); // first edge after the write lands
        @(negedge clk_i);
        check("mirror", 32'h000123, {8'h00, phys});
        @(posedge clk_i);
    endtask
    // mid-run reset with the test strap high: external control word
    task automatic t_strap;
        strap <= 1'b1;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        ahb(1'b0, 32'h8, 32'h0);
        check("control ext", 32'h08, rd);
        ahb(1'b0, 32'h0, 32'h0);
        check("bank select", 32'h1, rd);
        core_chk(8'h00, 16'h8123, 1'b0, 24'h008123);
    endtask
    // ------------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // cut a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        rst_i = 1'b1;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        hwrite_i = 1'b0;
        htrans_i = 2'b00;
        hwdata_i = 32'h0;
        strap = 1'b0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        t_reset_values();
        t_native();
        t_alt();
        t_strap();
        stop_test();
    end
endmodule // memory_bank_address_logic_test
`default_nettype wire
